// file: design/smsl_core.v
/*
  Serial port mode and status logic: master or slave byte engine with
  configuration, status, receive and transmit registers and one interrupt.
  Assumes a single-cycle register port on clock_in and serial pins that are
  asynchronous to it; slave clock well below a quarter of clock_in.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "smsl_regs.vh"
module smsl_core #(
  parameter DIV_W = 8
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // Register port
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // Interrupt
  output wire irq_out,
  // Serial clock pin
  input wire sclk_in,
  output wire sclk_out,
  output wire sclk_oe_out,
  // Master out slave in pin
  input wire mosi_in,
  output wire mosi_out,
  output wire mosi_oe_out,
  // Master in slave out pin
  input wire miso_in,
  output wire miso_out,
  output wire miso_oe_out,
  // Slave select pin
  input wire ss_n_in,
  output wire ss_n_out,
  output wire ss_n_oe_out
);
  reg rst_q1_r;
  reg rst_n_r;
  reg [7:0] cfg_one_r;
  reg [7:0] cfg_two_r;
  reg [7:0] mask_r;
  reg [7:0] tx_data_r;
  reg [7:0] rx_data_r;
  reg rx_full_r;
  reg rxof_r;
  reg multi_master_error_r;
  reg active_r;
  reg [3:0] edge_cnt_r;
  reg [7:0] tx_sh_r;
  reg [7:0] rx_sh_r;
  reg sclk_r;
  reg sclk_prev_r;
  reg ss_prev_r;
  reg ss_out_n_r;
  reg dout_r;
  reg [7:0] tx_sh_nxt;
  reg [7:0] rx_sh_nxt;
  reg [7:0] rdata_nxt;
  wire [3:0] pins_s;
  wire sclk_s;
  wire din_s;
  wire ss_n_s;
  wire tick;
  wire [DIV_W-1:0] div_limit;

  // Reset release through two flops
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_q1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_q1_r <= 1'b1;
      rst_n_r <= rst_q1_r;
    end
  end

  // Mode decode
  wire port_en = cfg_two_r[`SMSL_C2_PORT_EN];
  wire cpol = cfg_two_r[`SMSL_C2_CPOL];
  wire cpha = cfg_two_r[`SMSL_C2_CPHA];
  wire master_mode = port_en && cfg_two_r[`SMSL_C2_MASTER];
  wire slave_mode = port_en && !cfg_two_r[`SMSL_C2_MASTER];
  wire lsb_first = master_mode && cfg_two_r[`SMSL_C2_LSBF];
  wire ss_en = cfg_one_r[`SMSL_C1_SS_EN];
  wire overwrite_en = cfg_one_r[`SMSL_C1_OVERWRITE];
  wire [1:0] rate = cfg_one_r[`SMSL_C1_RATE_HI:`SMSL_C1_RATE_LO];

  // Pin synchronisers: select, clock and both data pins
  smsl_sync #(
    .W(4),
    .RST_VAL(4'h8)
  ) u_pin_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_r),
    .d_in({ss_n_in, sclk_in, miso_in, mosi_in}),
    .q_out(pins_s)
  );
  assign din_s = master_mode ? pins_s[1] : pins_s[0];
  assign sclk_s = pins_s[2];
  assign ss_n_s = pins_s[3];

  // Master half period is base shifted by rate
  assign div_limit = ((`SMSL_DIV_BASE << rate) - 8'h01);

  smsl_clkdiv #(
    .W(DIV_W)
  ) u_div (
    .clock_in(clock_in),
    .rst_n_in(rst_n_r),
    .run_in(active_r && master_mode),
    .limit_in(div_limit),
    .tick_out(tick)
  );

  // Register port strobes
  wire wr_tx = wr_in && (addr_in == `SMSL_ADDR_TX_DATA);
  wire wr_status = wr_in && (addr_in == `SMSL_ADDR_STATUS);
  wire rd_rx = rd_in && (addr_in == `SMSL_ADDR_RX_DATA);

  // Edge classification
  wire m_edge = active_r && master_mode && tick;
  wire s_edge = active_r && slave_mode && (sclk_s != sclk_prev_r);
  wire any_edge = m_edge || s_edge;
  wire lead_edge = !edge_cnt_r[0];
  wire sample_now = any_edge && (cpha ? !lead_edge : lead_edge);
  wire shift_now = any_edge && (cpha ? (lead_edge && (edge_cnt_r != 4'h0)) : !lead_edge);
  wire byte_done = any_edge && (edge_cnt_r == `SMSL_LAST_EDGE);
  wire slave_start = slave_mode && !active_r && !ss_n_s && ss_prev_r;
  wire slave_stop = slave_mode && active_r && ss_n_s;
  wire master_start = master_mode && !active_r && wr_tx;
  wire mm_fault = active_r && master_mode && ss_en && !ss_n_s;

  // Shift register next values
  always @*
  begin
    tx_sh_nxt = tx_sh_r;
    rx_sh_nxt = rx_sh_r;
    if (master_start)
      tx_sh_nxt = wdata_in;
    else if (slave_start || (byte_done && slave_mode))
      tx_sh_nxt = tx_data_r;
    else if (shift_now)
      tx_sh_nxt = lsb_first ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
    if (sample_now)
      rx_sh_nxt = lsb_first ? {din_s, rx_sh_r[7:1]} : {rx_sh_r[6:0], din_s};
  end

  // Transfer engine
  always @(posedge clock_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      active_r <= 1'b0;
      edge_cnt_r <= 4'h0;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      sclk_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      ss_prev_r <= 1'b1;
      ss_out_n_r <= 1'b1;
      dout_r <= 1'b0;
    end
    else
    begin
      sclk_prev_r <= sclk_s;
      ss_prev_r <= ss_n_s;
      tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      dout_r <= lsb_first ? tx_sh_nxt[0] : tx_sh_nxt[7];
      if (!port_en || mm_fault || slave_stop || (byte_done && master_mode))
      begin
        active_r <= 1'b0;
        edge_cnt_r <= 4'h0;
      end
      else if (master_start || slave_start)
      begin
        active_r <= 1'b1;
        edge_cnt_r <= 4'h0;
      end
      else if (any_edge)
        edge_cnt_r <= edge_cnt_r + 4'h1;
      // Master clock toggles from its idle level
      if (!active_r || !master_mode || mm_fault)
        sclk_r <= cpol;
      else if (m_edge)
        sclk_r <= !sclk_r;
      // Select held one cycle past the last edge so the far side still samples it
      ss_out_n_r <= !(master_start || (active_r && master_mode && !mm_fault));
    end
  end

  // Received byte taken at the end of each transfer
  wire [7:0] rx_byte = rx_sh_nxt;

  // Receive register and flags, set wins over clear
  always @(posedge clock_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
      rxof_r <= 1'b0;
      multi_master_error_r <= 1'b0;
    end
    else
    begin
      if (byte_done && (!rx_full_r || rd_rx))
      begin
        rx_data_r <= rx_byte;
        rx_full_r <= 1'b1;
      end
      else if (byte_done)
      begin
        rxof_r <= 1'b1;
        if (overwrite_en)
          rx_data_r <= rx_byte;
        // Otherwise old byte kept, new one dropped
      end
      else
      begin
        if (rd_rx || (wr_status && wdata_in[`SMSL_ST_RXFULL]))
          rx_full_r <= 1'b0;
        if (rd_rx || (wr_status && wdata_in[`SMSL_ST_RXOF]))
          rxof_r <= 1'b0;
      end
      if (byte_done && (!rx_full_r || rd_rx) && (rd_rx || (wr_status && wdata_in[`SMSL_ST_RXOF])))
        rxof_r <= 1'b0;
      if (mm_fault)
        multi_master_error_r <= 1'b1;
      else if (wr_status && wdata_in[`SMSL_ST_MULTI_MASTER_ERROR])
        multi_master_error_r <= 1'b0;
    end
  end

  // Software registers
  always @(posedge clock_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cfg_one_r <= `SMSL_C1_RESET;
      cfg_two_r <= `SMSL_C2_RESET; // Mode bit defaults to 1
      mask_r <= 8'h00;
      tx_data_r <= 8'h00;
    end
    else if (wr_in)
    begin
      case (addr_in)
        `SMSL_ADDR_CFG_ONE: cfg_one_r <= wdata_in;
        `SMSL_ADDR_CFG_TWO: cfg_two_r <= wdata_in;
        `SMSL_ADDR_IRQ_MASK: mask_r <= wdata_in;
        `SMSL_ADDR_TX_DATA: tx_data_r <= wdata_in;
        default: mask_r <= mask_r;
      endcase
    end
  end

  // Status view
  wire [7:0] status = {active_r, multi_master_error_r, rxof_r, rx_full_r, 4'h0};

  // Read data one cycle after the strobe, zero otherwise
  always @*
  begin
    rdata_nxt = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        `SMSL_ADDR_RX_DATA: rdata_nxt = rx_data_r;
        `SMSL_ADDR_CFG_ONE: rdata_nxt = cfg_one_r;
        `SMSL_ADDR_CFG_TWO: rdata_nxt = cfg_two_r;
        `SMSL_ADDR_STATUS: rdata_nxt = status;
        `SMSL_ADDR_IRQ_MASK: rdata_nxt = mask_r;
        `SMSL_ADDR_TX_DATA: rdata_nxt = tx_data_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge clock_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rdata_out <= 8'h00;
    else
      rdata_out <= rdata_nxt;
  end

  // Interrupt: sticky status bits gated by mask
  assign irq_out = |(status[6:4] & mask_r[6:4]);

  // Pin drive
  assign sclk_out = sclk_r;
  assign sclk_oe_out = master_mode;
  assign mosi_out = dout_r;
  assign mosi_oe_out = master_mode;
  assign miso_out = dout_r;
  assign miso_oe_out = slave_mode && !ss_n_s;
  assign ss_n_out = ss_out_n_r;
  assign ss_n_oe_out = master_mode && !ss_en;
endmodule
`default_nettype wire

// file: design/smsl_regs.vh
/*
  Register map, field positions, reset values and timing constants of the
  serial port mode and status logic.
  Assumes it is included by bare name from the core design file, the only one of the block that uses it.
*/
// What this block does
// - With clock phase 0, input is sampled on the first clock edge and every second one after, output changes on the others.
// - With clock phase 1, output changes on the third clock edge and every second one after, input is sampled on the second and every second one after.
// - As master, bit-order 0 shifts the most significant bit first and 1 the least significant bit first.
// - Status bit 7 reads 1 while a byte moves in master mode or while the select input is low in slave mode, and 0 otherwise.
// - With the select input enabled, an external select during a master transfer sets the error flag in status bit 6.
// - The multimaster error flag stays set until software clears it by a write.
// - Status bit 5 is set when a byte completes while the previous received byte is still unread.
// - Reading the receive data register clears the receive overflow flag.
// - On overflow with overwrite enabled, the new byte replaces the unread one.
// - Clock polarity 0 idles the clock low with a rising first edge, 1 idles it high with a falling first edge.
// - Master select 0 makes the port a slave, 1 a master.
// - Port enable 0 turns the whole serial interface off, 1 turns it on.
`ifndef SMSL_REGS_VH
`define SMSL_REGS_VH

// Register offsets
`define SMSL_ADDR_RX_DATA 8'h9B
`define SMSL_ADDR_CFG_ONE 8'hE8
`define SMSL_ADDR_CFG_TWO 8'hE9
`define SMSL_ADDR_STATUS 8'hEA
`define SMSL_ADDR_IRQ_MASK 8'hEB
`define SMSL_ADDR_TX_DATA 8'hEC

// Config one fields
`define SMSL_C1_SS_EN 5
`define SMSL_C1_OVERWRITE 3
`define SMSL_C1_RATE_HI 1
`define SMSL_C1_RATE_LO 0
`define SMSL_C1_RESET 8'h00

// Config two fields
`define SMSL_C2_PORT_EN 6
`define SMSL_C2_MASTER 4
`define SMSL_C2_CPOL 3
`define SMSL_C2_CPHA 2
`define SMSL_C2_LSBF 1
`define SMSL_C2_TRANSFER_IRQ_MODE 0
`define SMSL_C2_RESET 8'h01

// Status fields
`define SMSL_ST_BUSY 7
`define SMSL_ST_MULTI_MASTER_ERROR 6
`define SMSL_ST_RXOF 5
`define SMSL_ST_RXFULL 4

// Last edge index of a byte, divider base half period in cycles
`define SMSL_LAST_EDGE 4'hF
// Shortest half period must cover the input synchroniser plus the sampling cycle
`define SMSL_DIV_BASE 8'h04

`endif

// file: design/smsl_sync.v
/*
  Two flip-flop synchroniser for pins that come from outside the clock domain.
  Assumes the reset given is already synchronous to clock_in at release.
*/
`timescale 1ns/1ps
`default_nettype none
module smsl_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // Data
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_r;

  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end
    else
    begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: design/smsl_clkdiv.v
/*
  Divider giving a one-cycle enable pulse every limit_in+1 clocks while run_in.
  Assumes limit_in is held stable while running.
*/
`timescale 1ns/1ps
`default_nettype none
module smsl_clkdiv #(
  parameter W = 8
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // Control
  input wire run_in,
  input wire [W-1:0] limit_in,
  output wire tick_out
);
  reg [W-1:0] cnt_r;

  assign tick_out = run_in && (cnt_r == limit_in);

  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_r <= {W{1'b0}};
    else if (!run_in || tick_out)
      cnt_r <= {W{1'b0}};
    else
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
  end
endmodule
`default_nettype wire

// file: sim/smsl_checker.sv
/* Port checker for smsl_core.
   Bound from the bench top; sees core ports only. */
`timescale 1ns/1ps
`default_nettype none
module smsl_checker (
  input wire logic clock_in, rst_n_in, wr_in,
  input wire logic [7:0] addr_in, wdata_in,
  input wire logic sclk_out, sclk_oe_out, mosi_out,
  input wire logic mosi_oe_out, miso_oe_out,
  input wire logic ss_n_in, ss_n_out, ss_n_oe_out
);
  logic [7:0] c1_r, c2_r;
  logic [4:0] ne_r;
  logic sk_r, w1_r, w2_r;
  wire logic q = !w1_r && !w2_r;
  wire logic tg = sclk_out != sk_r;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Config shadow and edge count per frame
  always @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      c1_r <= 8'h00;
      c2_r <= 8'h01;
      ne_r <= 5'h00;
      {sk_r, w1_r, w2_r} <= 3'h0;
    end
    else
    begin
      if (wr_in && addr_in == 8'hE8) c1_r <= wdata_in;
      if (wr_in && addr_in == 8'hE9) c2_r <= wdata_in;
      ne_r <= ss_n_out ? 5'h00 : ne_r + {4'h0, tg};
      {sk_r, w1_r, w2_r} <= {sclk_out, wr_in, w1_r};
    end
  a_idle_level: assert property (q && sclk_oe_out && ss_n_out && !c1_r[5] |-> sclk_out == c2_r[3])
    else $error("idle level");
  a_clock_drive: assert property (q |-> sclk_oe_out == (c2_r[6] && c2_r[4]))
    else $error("clock drive");
  a_slave_out: assert property (miso_oe_out |-> !sclk_oe_out && !mosi_oe_out)
    else $error("slave drive");
  a_off_quiet: assert property (q && !c2_r[6] |-> !(sclk_oe_out | mosi_oe_out | miso_oe_out | ss_n_oe_out))
    else $error("off drive");
  a_select_in: assert property (q && sclk_oe_out |-> ss_n_oe_out == !c1_r[5])
    else $error("select drive");
  a_byte_start: assert property (wr_in && addr_in == 8'hEC && sclk_oe_out && ss_n_oe_out && ss_n_out |=> !ss_n_out)
    else $error("no start");
  a_byte_edges: assert property ($rose(ss_n_out) && !c1_r[5] && c2_r[6] |-> ne_r == 5'h10)
    else $error("edge count");
  a_sample_hold: assert property (!ss_n_out && tg && ne_r[0] == c2_r[2] |-> $stable(mosi_out))
    else $error("data moved");
  a_multi_abort: assert property ((!ss_n_out && c1_r[5] && !ss_n_in) [*3] |-> ##[0:6] ss_n_out)
    else $error("no abort");
  c_master: cover property ($rose(ss_n_out));
  c_fault: cover property (sclk_oe_out && c1_r[5] && !ss_n_in);
  c_slave: cover property (miso_oe_out);
endmodule
`default_nettype wire

// file: sim/smsl_peer.sv
/* Far-side slave, MSB first.
   Assumes pin wires resolved by the bench. */
`timescale 1ns/1ps
`default_nettype none
module smsl_peer (
  input wire logic sclk_in, mosi_in, ss_n_in, cpha_in,
  input wire logic [7:0] tx_in,
  output var logic miso_out,
  output var logic [7:0] rx_out
);
  int n;
  int e;
  initial
  begin
    miso_out = 1'b0;
    rx_out = 8'h00;
  end
  always @(negedge ss_n_in)
  begin
    e = 0;
    n = cpha_in ? 0 : 1;
    if (!cpha_in) miso_out = tx_in[7];
  end
  always @(sclk_in)
    if (!ss_n_in)
    begin
      e = e + 1;
      if (e[0] != cpha_in) rx_out = {rx_out[6:0], mosi_in};
      else if (n < 8)
      begin
        miso_out = tx_in[7 - n];
        n = n + 1;
      end
    end
  // Released line shows the inverse
  always @(posedge ss_n_in) miso_out = ~miso_out;
endmodule
`default_nettype wire

// file: sim/smsl_core_tb.sv
/* Bench for smsl_core: register tasks and scenarios.
   Assumes peer and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module smsl_core_tb;
  logic clock_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic tb_sclk = 1'b0, tb_mosi = 1'b0, tb_ss_n = 1'b1, pcpha = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, ptx = 8'h5A;
  wire logic [7:0] rdata_out, prx;
  wire logic irq_out, sclk_out, sclk_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, ss_n_out, ss_n_oe_out, p_miso;
  wire logic sclk_in = sclk_oe_out ? sclk_out : tb_sclk;
  wire logic mosi_in = mosi_oe_out ? mosi_out : tb_mosi;
  wire logic miso_in = miso_oe_out ? miso_out : p_miso;
  wire logic ss_n_in = ss_n_oe_out ? ss_n_out : tb_ss_n;
  int err_count = 0;
  int samples_checked = 0;
  smsl_core smsl_core_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .sclk_in(sclk_in),
    .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .mosi_in(mosi_in), .mosi_out(mosi_out),
    .mosi_oe_out(mosi_oe_out), .miso_in(miso_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
    .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe_out(ss_n_oe_out));
  smsl_peer smsl_peer_inst (.sclk_in(sclk_in), .mosi_in(mosi_in), .ss_n_in(ss_n_in), .cpha_in(pcpha),
    .tx_in(ptx), .miso_out(p_miso), .rx_out(prx));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string w, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic rchk(input string w, input logic [7:0] a, exp);
    logic [7:0] d;
    rd(a, d);
    check(w, d, exp);
  endtask
  // Polls busy with a bound
  task automatic idle;
    logic [7:0] d;
    int i;
    d = 8'h80;
    for (i = 0; i < 300 && d[7] !== 1'b0; i++) rd(8'hEA, d);
    if (d[7] !== 1'b0)
    begin
      err_count++;
      print_verdict;
    end
  endtask
  initial forever #2.5 clock_in = ~clock_in;
  initial
  begin : main
    logic [7:0] d, e;
    int i;
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rchk("config two", 8'hE9, 8'h01);
    rchk("status", 8'hEA, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      d = 8'h90 | {5'h00, i[2:0]};
      e = {<<{d}};
      pcpha = i[1];
      wr(8'hE9, {4'h5, i[2:0], 1'b1});
      wr(8'hEC, d);
      rchk("busy", 8'hEA, 8'h80);
      idle;
      check("sent", prx, i[0] ? e : d);
      rd(8'h9B, e);
      check("got", e, 8'h5A);
    end
    wr(8'hE9, 8'h51);
    pcpha = 1'b0;
    wr(8'hEB, 8'h20);
    for (i = 0; i < 2; i++)
    begin
      wr(8'hE8, {4'h0, i[0], 2'h0, i[0]});
      ptx = 8'h11;
      wr(8'hEC, 8'h00);
      idle;
      check("masked irq", {7'h00, irq_out}, 8'h00);
      ptx = 8'h22;
      wr(8'hEC, 8'h00);
      idle;
      check("irq", {7'h00, irq_out}, 8'h01);
      rchk("overflow", 8'hEA, 8'h30);
      rchk("kept", 8'h9B, i[0] ? 8'h22 : 8'h11);
      rchk("cleared", 8'hEA, 8'h00);
      check("irq off", {7'h00, irq_out}, 8'h00);
    end
    wr(8'hE8, 8'h20);
    wr(8'hEC, 8'h00);
    repeat (8) @(posedge clock_in);
    tb_ss_n <= 1'b0;
    repeat (8) @(posedge clock_in);
    tb_ss_n <= 1'b1;
    rchk("fault", 8'hEA, 8'h40);
    rchk("fault held", 8'hEA, 8'h40);
    wr(8'hEA, 8'h40);
    rchk("fault gone", 8'hEA, 8'h00);
    wr(8'hE8, 8'h00);
    wr(8'hE9, 8'h41);
    wr(8'hEC, 8'hA5);
    tb_ss_n <= 1'b0;
    d = 8'hC3;
    for (i = 7; i >= 0; i--)
    begin
      tb_mosi <= d[i];
      if (i == 3) rchk("slave busy", 8'hEA, 8'h80);
      repeat (12) @(posedge clock_in);
      e = {e[6:0], miso_out};
      tb_sclk <= 1'b1;
      repeat (13) @(posedge clock_in);
      tb_sclk <= 1'b0;
    end
    repeat (4) @(posedge clock_in);
    tb_ss_n <= 1'b1;
    repeat (8) @(posedge clock_in);
    check("slave sent", e, 8'hA5);
    rchk("slave got", 8'h9B, 8'hC3);
    wr(8'hE9, 8'h01);
    wr(8'hEC, 8'h55);
    rchk("off", 8'hEA, 8'h00);
    print_verdict;
  end
endmodule
bind smsl_core smsl_checker smsl_checker_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .wr_in(wr_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .mosi_out(mosi_out),
  .mosi_oe_out(mosi_oe_out), .miso_oe_out(miso_oe_out), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out),
  .ss_n_oe_out(ss_n_oe_out));
`default_nettype wire
